// ==== hdl/lhp_module_end.sv ====
// Module end: two display controllers behind one shared parallel port
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Select high means display data, low instruction
// - Read cycle drives bus, write cycle samples
// - First select directs cycle to first controller
// - Second select directs cycle to second controller
// - 68 style resets on falling reset pin
// - 80 style resets on rising reset pin
// - Static pin level picks 68 or 80 style
// - Slave controller takes frame polarity as input
// - Master controller drives frame polarity out
// - Busy controller ignores all but status read
module lhp_module_end
    import lhp_pkg::*;
#(
    parameter int BUSY_CYCLES = BUSY_CYC,
    parameter int FRAME_CYCLES = FRAME_CYC,
    parameter int MASTER_INDEX = 0
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    lhp_bus_if.device bus,
    input wire logic [NCTRL-1:0][DATA_W-1:0] disp_rd_data_in,
    output logic wr_valid_out,
    output logic wr_is_data_out,
    output logic [DATA_W-1:0] wr_data_out,
    output logic rd_taken_out,
    output logic event_ctrl_out,
    output logic module_reset_out,
    output logic style_68_out,
    output logic style_known_out,
    output logic [NCTRL-1:0] busy_out,
    output logic [NCTRL-1:0] frame_phase_out
);
    // ==========================================================
    // Elaboration checks
    generate
        if (BUSY_CYCLES < 1 || BUSY_CYCLES >= (1 << CNT_W)) begin : g_bad_busy
            $error("BUSY_CYCLES out of range");
        end
        if (FRAME_CYCLES < 2 || FRAME_CYCLES >= (1 << CNT_W)) begin : g_bad_frame
            $error("FRAME_CYCLES out of range");
        end
        if (MASTER_INDEX < 0 || MASTER_INDEX >= NCTRL) begin : g_bad_master
            $error("MASTER_INDEX out of range");
        end
    endgenerate

    localparam logic [CNT_W-1:0] BUSY_LOAD = CNT_W'(BUSY_CYCLES);
    localparam logic [CNT_W-1:0] FRAME_LAST = CNT_W'(FRAME_CYCLES - 1);
    localparam int SLAVE_INDEX = 1 - MASTER_INDEX;

    // ==========================================================
    // State
    typedef struct packed {
        logic [SETTLE_W-1:0] settle;
        logic style_known;
        logic style68;
        logic pin_prev;
        logic strobe_prev;
        logic cyc_read;
        logic cyc_data;
        logic [NCTRL-1:0] cyc_sel;
        logic [NCTRL-1:0] busy;
        logic [NCTRL-1:0][CNT_W-1:0] busy_cnt;
        logic [DATA_W-1:0] dout;
        logic dout_oe;
        logic wr_valid;
        logic wr_is_data;
        logic [DATA_W-1:0] wr_data;
        logic rd_taken;
        logic ev_ctrl;
        logic mod_reset;
        logic fp_out;
        logic fp_oe;
        logic [CNT_W-1:0] fp_cnt;
        logic [NCTRL-1:0] frame_phase;
    } lhp_dev_state_t;

    lhp_dev_state_t q;
    lhp_dev_state_t d;

    logic pin;
    logic rst_evt;
    logic strobe;
    logic is_read;
    logic end_evt;
    logic [NCTRL-1:0] sel;
    logic [NCTRL-1:0] target;

    // ==========================================================
    // Next state
    always_comb begin
        d = q;
        d.wr_valid = 1'b0;
        d.rd_taken = 1'b0;
        d.mod_reset = 1'b0;
        pin = bus.reset_and_bus_style_pin;
        d.pin_prev = pin;
        d.settle = {q.settle[SETTLE_W-2:0], 1'b1};
        // Style is caught once the pin has had time to settle after release
        if (q.settle[SETTLE_W-1] && !q.style_known) begin
            d.style_known = 1'b1;
            d.style68 = pin;
        end
        // Module reset on the edge that belongs to the style in use
        rst_evt = 1'b0;
        if (q.style_known) begin
            if (q.style68 == STYLE_68) begin
                rst_evt = q.pin_prev && !pin;
            end else begin
                rst_evt = !q.pin_prev && pin;
            end
        end

        sel = {bus.second_controller_select, bus.first_controller_select};
        if (q.style68 == STYLE_68) begin
            strobe = bus.enable_strobe;
            is_read = bus.read_select;
        end else begin
            strobe = !bus.read_strobe_n || !bus.write_strobe_n;
            is_read = !bus.read_strobe_n;
        end
        strobe = strobe && q.style_known;
        end_evt = q.strobe_prev && !strobe;
        d.strobe_prev = strobe;
        // Direction and target are held from inside the strobe, since
        // 80 style has no direction left once its strobe has ended
        if (strobe) begin
            d.cyc_read = is_read;
            d.cyc_data = bus.data_instr_select;
            d.cyc_sel = sel;
        end
        // First controller wins if both selects are raised
        target = q.cyc_sel[0] ? 2'b01 : (q.cyc_sel[1] ? 2'b10 : 2'b00);

        for (int i = 0; i < NCTRL; i++) begin
            if (q.busy[i]) begin
                if (q.busy_cnt[i] == CNT_ONE) begin
                    d.busy[i] = 1'b0;
                end
                d.busy_cnt[i] = q.busy_cnt[i] - CNT_ONE;
            end
        end

        // ======================================================
        // Completed cycles
        if (end_evt && target != 2'b00) begin
            d.ev_ctrl = target[1];
            if (!q.cyc_read && !q.busy[target[1]]) begin
                // Sampled while the host still holds data after the strobe
                d.wr_valid = 1'b1;
                d.wr_is_data = q.cyc_data;
                d.wr_data = bus.data_bus;
                d.busy[target[1]] = 1'b1;
                d.busy_cnt[target[1]] = BUSY_LOAD;
            end else if (q.cyc_read && q.cyc_data && !q.busy[target[1]]) begin
                d.rd_taken = 1'b1;
            end
        end

        // ======================================================
        // Read drive
        d.dout_oe = 1'b0;
        d.dout = DATA_ZERO;
        if (strobe && is_read) begin
            for (int i = NCTRL - 1; i >= 0; i--) begin
                if (sel[i]) begin
                    if (!bus.data_instr_select) begin
                        d.dout_oe = 1'b1;
                        d.dout = DATA_ZERO;
                        d.dout[BUSY_BIT] = q.busy[i];
                    end else if (!q.busy[i]) begin
                        d.dout_oe = 1'b1;
                        d.dout = disp_rd_data_in[i];
                    end else begin
                        d.dout_oe = 1'b0;
                        d.dout = DATA_ZERO;
                    end
                end
            end
        end

        // ======================================================
        // Frame polarity: master drives, slave follows the line
        d.fp_oe = 1'b1;
        if (q.fp_cnt == FRAME_LAST) begin
            d.fp_cnt = CNT_ZERO;
            d.fp_out = !q.fp_out;
        end else begin
            d.fp_cnt = q.fp_cnt + CNT_ONE;
        end
        d.frame_phase[MASTER_INDEX] = q.fp_out;
        d.frame_phase[SLAVE_INDEX] = bus.frame_polarity;

        if (rst_evt) begin
            d.busy = '0;
            d.busy_cnt = '0;
            d.dout_oe = 1'b0;
            d.dout = DATA_ZERO;
            d.wr_valid = 1'b0;
            d.rd_taken = 1'b0;
            d.strobe_prev = 1'b0;
            d.fp_cnt = CNT_ZERO;
            d.fp_out = 1'b0;
            d.mod_reset = 1'b1;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs, all from flip-flops
    assign bus.dev_data = q.dout;
    assign bus.dev_data_oe = q.dout_oe;
    assign bus.frame_polarity_o = q.fp_out;
    assign bus.frame_polarity_oe = q.fp_oe;
    assign wr_valid_out = q.wr_valid;
    assign wr_is_data_out = q.wr_is_data;
    assign wr_data_out = q.wr_data;
    assign rd_taken_out = q.rd_taken;
    assign event_ctrl_out = q.ev_ctrl;
    assign module_reset_out = q.mod_reset;
    assign style_68_out = q.style68;
    assign style_known_out = q.style_known;
    assign busy_out = q.busy;
    assign frame_phase_out = q.frame_phase;
endmodule
`default_nettype wire

// ==== common/lhp_pkg.sv ====
// Shared constants and types for the dual-controller LCD host port
package lhp_pkg;
    // ==========================================================
    // Widths
    localparam int DATA_W = 8;
    localparam int NCTRL = 2;
    localparam int BUSY_BIT = 7;
    localparam int CNT_W = 12;
    localparam int SETTLE_W = 2;

    // ==========================================================
    // Bus styles carried by the reset and bus style pin
    localparam logic STYLE_68 = 1'b1;
    localparam logic STYLE_80 = 1'b0;

    // ==========================================================
    // Timing, nanoseconds as printed, cycles derived at 50 MHz
    localparam int CLK_NS = 20;
    localparam int SETUP_NS = 20;
    localparam int STROBE_NS = 200;
    localparam int HOLD_NS = 10;
    localparam int CYCLE_NS = 1000;
    localparam int RESET_PULSE_NS = 1000;
    localparam int BUSY_NS = 800;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYCLE_CYC = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_CYC = CYCLE_CYC - SETUP_CYC - STROBE_CYC - HOLD_CYC;
    localparam int RESET_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int BUSY_CYC = (BUSY_NS + CLK_NS - 1) / CLK_NS;
    localparam int FRAME_CYC = 2048;

    // ==========================================================
    // Reset values and fixed words
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

    // ==========================================================
    // Host bus cycle sequencer
    typedef enum logic [2:0] {
        LHP_IDLE,
        LHP_SETUP,
        LHP_STROBE,
        LHP_HOLD,
        LHP_GAP,
        LHP_RESET
    } lhp_host_state_t;
endpackage

// ==== common/lhp_bus_if.sv ====
// Pin-level carrier between the host and the LCD module
`timescale 1ns/10ps
`default_nettype none
interface lhp_bus_if;
    import lhp_pkg::*;
    logic data_instr_select;
    logic read_select;
    logic first_controller_select;
    logic second_controller_select;
    logic reset_and_bus_style_pin;
    logic enable_strobe;
    logic read_strobe_n;
    logic write_strobe_n;
    logic [DATA_W-1:0] host_data;
    logic host_data_oe;
    logic [DATA_W-1:0] dev_data;
    logic dev_data_oe;
    logic frame_polarity_o;
    logic frame_polarity_oe;
    logic [DATA_W-1:0] data_bus;
    logic frame_polarity;

    // Wire levels; an undriven line reads low
    assign data_bus = host_data_oe ? host_data : (dev_data_oe ? dev_data : DATA_ZERO);
    assign frame_polarity = frame_polarity_oe ? frame_polarity_o : 1'b0;

    modport host (
        output data_instr_select, read_select, first_controller_select,
        output second_controller_select, reset_and_bus_style_pin,
        output enable_strobe, read_strobe_n, write_strobe_n, host_data, host_data_oe,
        input data_bus, dev_data_oe
    );
    modport device (
        input data_instr_select, read_select, first_controller_select,
        input second_controller_select, reset_and_bus_style_pin,
        input enable_strobe, read_strobe_n, write_strobe_n, data_bus, frame_polarity,
        output dev_data, dev_data_oe, frame_polarity_o, frame_polarity_oe
    );
endinterface
`default_nettype wire

// ==== hdl/lhp_host_end.sv ====
// Host end: sequences 68 or 80 style bus cycles toward the LCD module
`timescale 1ns/10ps
`default_nettype none
module lhp_host_end
    import lhp_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    lhp_bus_if.host bus,
    input wire logic style_68_in,
    input wire logic mod_reset_req_in,
    input wire logic cmd_valid_in,
    input wire logic cmd_read_in,
    input wire logic cmd_data_in,
    input wire logic cmd_ctrl_in,
    input wire logic [DATA_W-1:0] cmd_wdata_in,
    output logic cmd_ready_out,
    output logic rsp_valid_out,
    output logic [DATA_W-1:0] rsp_data_out
);
    // ==========================================================
    // Elaboration checks
    generate
        if (GAP_CYC < 1) begin : g_bad_gap
            $error("Cycle time shorter than its phases");
        end
    endgenerate

    localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(SETUP_CYC - 1);
    localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYC - 1);
    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYC - 1);
    localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(GAP_CYC - 1);
    localparam logic [CNT_W-1:0] RESET_LAST = CNT_W'(RESET_CYC - 1);

    // ==========================================================
    // State
    typedef struct packed {
        lhp_host_state_t st;
        logic [CNT_W-1:0] cnt;
        logic ready;
        logic a0;
        logic rw;
        logic [NCTRL-1:0] cs;
        logic e;
        logic rd_n;
        logic wr_n;
        logic [DATA_W-1:0] hdata;
        logic hoe;
        logic pin;
        logic rsp_valid;
        logic [DATA_W-1:0] rsp_data;
    } lhp_host_q_t;

    lhp_host_q_t q;
    lhp_host_q_t d;

    always_comb begin
        d = q;
        d.rsp_valid = 1'b0;
        d.cnt = q.cnt - CNT_ONE;
        unique case (q.st)
            LHP_IDLE: begin
                d.pin = style_68_in;
                if (mod_reset_req_in) begin
                    // Leaving the style level is the reset edge of either style
                    d.pin = !style_68_in;
                    d.ready = 1'b0;
                    d.cnt = RESET_LAST;
                    d.st = LHP_RESET;
                end else if (cmd_valid_in && q.ready) begin
                    d.ready = 1'b0;
                    d.a0 = cmd_data_in;
                    d.rw = cmd_read_in;
                    d.cs = cmd_ctrl_in ? 2'b10 : 2'b01;
                    d.hdata = cmd_wdata_in;
                    d.hoe = !cmd_read_in;
                    d.cnt = SETUP_LAST;
                    d.st = LHP_SETUP;
                end else if (!q.ready) begin
                    d.ready = 1'b1;
                end
            end
            LHP_SETUP: begin
                if (q.cnt == CNT_ZERO) begin
                    if (style_68_in == STYLE_68) begin
                        d.e = 1'b1;
                    end else begin
                        d.rd_n = !q.rw;
                        d.wr_n = q.rw;
                    end
                    d.cnt = STROBE_LAST;
                    d.st = LHP_STROBE;
                end
            end
            LHP_STROBE: begin
                if (q.cnt == CNT_ZERO) begin
                    if (q.rw) begin
                        d.rsp_valid = 1'b1;
                        d.rsp_data = bus.data_bus;
                    end
                    d.e = 1'b0;
                    d.rd_n = 1'b1;
                    d.wr_n = 1'b1;
                    d.cnt = HOLD_LAST;
                    d.st = LHP_HOLD;
                end
            end
            LHP_HOLD: begin
                if (q.cnt == CNT_ZERO) begin
                    d.cs = 2'b00;
                    d.hoe = 1'b0;
                    d.cnt = GAP_LAST;
                    d.st = LHP_GAP;
                end
            end
            LHP_GAP: begin
                // Full cycle time covers the busy period, so no polling is needed
                if (q.cnt == CNT_ZERO) begin
                    d.ready = 1'b1;
                    d.st = LHP_IDLE;
                end
            end
            LHP_RESET: begin
                if (q.cnt == CNT_ZERO) begin
                    d.pin = style_68_in;
                    d.cnt = GAP_LAST;
                    d.st = LHP_GAP;
                end
            end
            default: begin
                d.st = LHP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '{st: LHP_IDLE, cnt: CNT_ZERO, ready: 1'b0, a0: 1'b0, rw: 1'b0,
                   cs: 2'b00, e: 1'b0, rd_n: 1'b1, wr_n: 1'b1, hdata: DATA_ZERO,
                   hoe: 1'b0, pin: STYLE_68, rsp_valid: 1'b0, rsp_data: DATA_ZERO};
        end else begin
            q <= d;
        end
    end

    assign bus.data_instr_select = q.a0;
    assign bus.read_select = q.rw;
    assign bus.first_controller_select = q.cs[0];
    assign bus.second_controller_select = q.cs[1];
    assign bus.reset_and_bus_style_pin = q.pin;
    assign bus.enable_strobe = q.e;
    assign bus.read_strobe_n = q.rd_n;
    assign bus.write_strobe_n = q.wr_n;
    assign bus.host_data = q.hdata;
    assign bus.host_data_oe = q.hoe;
    assign cmd_ready_out = q.ready;
    assign rsp_valid_out = q.rsp_valid;
    assign rsp_data_out = q.rsp_data;
endmodule
`default_nettype wire

// ==== bench/lhp_bus_chk.sv ====
// Checker on the wire between the host end and the module end
`timescale 1ns/10ps
`default_nettype none
module lhp_bus_chk
    import lhp_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic data_instr_select,
    input wire logic read_select,
    input wire logic first_controller_select,
    input wire logic second_controller_select,
    input wire logic enable_strobe,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [DATA_W-1:0] host_data,
    input wire logic host_data_oe,
    input wire logic [DATA_W-1:0] dev_data,
    input wire logic dev_data_oe,
    input wire logic frame_polarity_oe
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // ==========================================================
    // Strobe shapes, ten cycles of 20 ns each
    sequence s_enable_held;
        enable_strobe [*8] ##1 enable_strobe [*2];
    endsequence
    sequence s_write_low;
        !write_strobe_n [*8] ##1 !write_strobe_n [*2];
    endsequence

    // ==========================================================
    // Assertions
    a_host_dev_excl: assert property (host_data_oe |-> !dev_data_oe)
        else $error("both ends drive the data bus");
    a_unsel_released: assert property (!first_controller_select && !second_controller_select
        && !$past(first_controller_select) && !$past(second_controller_select) |-> !dev_data_oe)
        else $error("unselected module drives the bus");
    a_master_drives_fp: assert property ($past(rst_n_in) |-> frame_polarity_oe)
        else $error("frame polarity not driven by master");
    a_status_low_bits: assert property (dev_data_oe && !data_instr_select
        |-> dev_data[BUSY_BIT-1:0] == 7'h00)
        else $error("status word has stray bits");
    a_one_style_only: assert property (enable_strobe |-> read_strobe_n && write_strobe_n)
        else $error("strobes of both styles active");
    a_enable_width: assert property ($rose(enable_strobe) |-> s_enable_held ##1 !enable_strobe)
        else $error("enable strobe width wrong");
    a_write_width: assert property ($fell(write_strobe_n) |-> s_write_low ##1 write_strobe_n)
        else $error("write strobe width wrong");
    a_read_drive: assert property (($fell(read_strobe_n) || ($rose(enable_strobe) && read_select))
        && (first_controller_select || second_controller_select) |-> ##[1:2] dev_data_oe)
        else $error("read cycle not answered");
    a_select_in_strobe: assert property ((enable_strobe || !read_strobe_n || !write_strobe_n)
        |-> (first_controller_select || second_controller_select) && $stable(data_instr_select))
        else $error("select or kind changed in strobe");
    a_wdata_held: assert property (!write_strobe_n || (enable_strobe && !read_select)
        |-> host_data_oe && $stable(host_data))
        else $error("write data not held");
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for host end and module end joined by the bus
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import lhp_pkg::*;
    // ==========================================================
    // Signals
    logic clk_in, rst_n_in, style_68_in, mod_reset_req_in;
    logic cmd_valid_in, cmd_read_in, cmd_data_in, cmd_ctrl_in;
    logic [DATA_W-1:0] cmd_wdata_in, rsp_data_out, wr_data_out;
    logic cmd_ready_out, rsp_valid_out, wr_valid_out, wr_is_data_out, rd_taken_out;
    logic event_ctrl_out, module_reset_out, style_68_out, style_known_out;
    logic [NCTRL-1:0] busy_out, frame_phase_out;
    logic [NCTRL-1:0][DATA_W-1:0] disp_rd_data_in;
    int fail_count = 0;
    int total_checks = 0;
    int cyc = 0;

    lhp_bus_if bus();
    lhp_host_end u_lhp_host_end (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus(bus),
        .style_68_in(style_68_in), .mod_reset_req_in(mod_reset_req_in),
        .cmd_valid_in(cmd_valid_in), .cmd_read_in(cmd_read_in), .cmd_data_in(cmd_data_in),
        .cmd_ctrl_in(cmd_ctrl_in), .cmd_wdata_in(cmd_wdata_in), .cmd_ready_out(cmd_ready_out),
        .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out));
    // Short frame so polarity flips are seen in a few cycles
    lhp_module_end #(.FRAME_CYCLES(8)) u_lhp_module_end (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .bus(bus), .disp_rd_data_in(disp_rd_data_in), .wr_valid_out(wr_valid_out),
        .wr_is_data_out(wr_is_data_out), .wr_data_out(wr_data_out), .rd_taken_out(rd_taken_out),
        .event_ctrl_out(event_ctrl_out), .module_reset_out(module_reset_out),
        .style_68_out(style_68_out), .style_known_out(style_known_out), .busy_out(busy_out),
        .frame_phase_out(frame_phase_out));
    lhp_bus_chk u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .data_instr_select(bus.data_instr_select), .read_select(bus.read_select),
        .first_controller_select(bus.first_controller_select),
        .second_controller_select(bus.second_controller_select),
        .enable_strobe(bus.enable_strobe), .read_strobe_n(bus.read_strobe_n),
        .write_strobe_n(bus.write_strobe_n), .host_data(bus.host_data),
        .host_data_oe(bus.host_data_oe), .dev_data(bus.dev_data), .dev_data_oe(bus.dev_data_oe),
        .frame_polarity_oe(bus.frame_polarity_oe));

    // ==========================================================
    // Clock and hang guard
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 6000) begin
            fail_count++;
            stop_test();
        end
    end

    // ==========================================================
    // Tasks
    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic do_reset(input logic st);
        @(negedge clk_in);
        rst_n_in = 1'b0;
        style_68_in = st;
        repeat (16) @(negedge clk_in);
        rst_n_in = 1'b1;
        // Device latches the style on the third edge after release
        repeat (4) @(negedge clk_in);
        chk(style_known_out === 1'b1 && style_68_out === st, "bus style");
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (cmd_ready_out !== 1'b1 && n < 200) begin
            @(negedge clk_in);
            n++;
        end
        chk(cmd_ready_out === 1'b1, "host not ready");
    endtask
    task automatic send(input logic rd, input logic a0, input logic ct, input logic [7:0] wd);
        wait_ready();
        cmd_valid_in = 1'b1;
        cmd_read_in = rd;
        cmd_data_in = a0;
        cmd_ctrl_in = ct;
        cmd_wdata_in = wd;
        @(negedge clk_in);
        cmd_valid_in = 1'b0;
    endtask
    task automatic wr_chk(input logic a0, input logic ct, input logic [7:0] wd);
        int n;
        n = 0;
        send(1'b0, a0, ct, wd);
        while (wr_valid_out !== 1'b1 && n < 30) begin
            @(negedge clk_in);
            n++;
        end
        chk(wr_valid_out === 1'b1 && wr_data_out === wd, "write byte");
        chk(wr_is_data_out === a0, "write kind");
        chk(event_ctrl_out === ct, "write target");
        @(negedge clk_in);
        chk(busy_out === (ct ? 2'b10 : 2'b01), "busy target");
    endtask
    task automatic rd_chk(input logic a0, input logic ct, input logic [7:0] exp);
        int n;
        n = 0;
        send(1'b1, a0, ct, 8'h00);
        while (rsp_valid_out !== 1'b1 && n < 30) begin
            @(negedge clk_in);
            n++;
        end
        chk(rsp_valid_out === 1'b1 && rsp_data_out === exp, "read byte");
        @(negedge clk_in);
        chk(rd_taken_out === a0, "read taken");
    endtask
    task automatic mod_reset(input logic st);
        int n, t;
        n = 0;
        t = -1;
        wait_ready();
        mod_reset_req_in = 1'b1;
        while (t < 0 && n < 120) begin
            @(negedge clk_in);
            n++;
            if (cmd_ready_out === 1'b0) mod_reset_req_in = 1'b0;
            if (module_reset_out === 1'b1) t = n;
        end
        // Both styles act as the pin leaves its style level, not on its return
        if (st) chk(t > 0 && t <= 10, "reset on falling pin");
        else chk(t > 0 && t <= 10, "reset on rising pin");
        chk(style_68_out === st, "style kept after reset");
    endtask
    task automatic frame_chk();
        logic p0, p1;
        int flips;
        flips = 0;
        p0 = bus.frame_polarity;
        p1 = p0;
        repeat (40) begin
            @(negedge clk_in);
            if (bus.frame_polarity !== p0) flips++;
            else if (p0 === p1) chk(frame_phase_out === {p0, p0}, "slave follows");
            p1 = p0;
            p0 = bus.frame_polarity;
        end
        chk(bus.frame_polarity_oe === 1'b1 && flips >= 2, "master drives phase");
    endtask

    // ==========================================================
    // Main sequence: the same traffic in 68 style, then in 80 style
    initial begin
        rst_n_in = 1'b0;
        style_68_in = STYLE_68;
        mod_reset_req_in = 1'b0;
        cmd_valid_in = 1'b0;
        cmd_read_in = 1'b0;
        cmd_data_in = 1'b0;
        cmd_ctrl_in = 1'b0;
        cmd_wdata_in = 8'h00;
        disp_rd_data_in[0] = 8'hA1;
        disp_rd_data_in[1] = 8'hB2;
        for (int s = 1; s >= 0; s--) begin
            do_reset(s[0]);
            frame_chk();
            wr_chk(1'b1, 1'b0, 8'h5A);
            wr_chk(1'b0, 1'b0, 8'hFF);
            wr_chk(1'b0, 1'b1, 8'h00);
            rd_chk(1'b1, 1'b0, 8'hA1);
            rd_chk(1'b1, 1'b1, 8'hB2);
            rd_chk(1'b0, 1'b0, 8'h00);
            rd_chk(1'b0, 1'b1, 8'h00);
            mod_reset(s[0]);
            rd_chk(1'b1, 1'b1, 8'hB2);
        end
        stop_test();
    end
endmodule
`default_nettype wire
